// ==== design/sst_top.sv ====
// Slave-capable synchronous serial transmitter with a Wishbone slave port.
`timescale 1ns/100ps
// Notes on behaviour
// - Control bit picks master (device drives clock pin) or slave (pin input).
// - Length control bit picks seven or eight data bits; the mode bit is only stored and read back.
// - Slave shift clock comes from sampling the clock pin each system edge.
// - Written byte moves to shift register one system cycle after write if idle, else one cycle after the frame ends.
// - LSB driven at next falling shift edge after load; others on later falls.
// - Frame ends after the top bit: bit 7 long, bit 6 short.
// - Copy into shift register sets the buffer-empty flag, unless a buffer write lands in the same cycle.
// - Frame ends with buffer still empty: transmit-complete flag is set.
module sst_top #(
    parameter int BAUD_DIV_LOG2 = sst_pkg::BAUD_DIV_LOG2
) (
    input  wire logic        CLK_I,
    input  wire logic        SRST_I,
    input  wire logic        CE_I,
    input  wire logic        CYC_I,
    input  wire logic        STB_I,
    input  wire logic        WE_I,
    input  wire logic [7:0]  ADR_I,
    input  wire logic [3:0]  SEL_I,
    input  wire logic [31:0] DAT_I,
    output logic      [31:0] DAT_O,
    output logic             ACK_O,
    input  wire logic        BAUD_CLK_I,
    input  wire logic        TXC_I,
    output logic             TXC_O,
    output logic             TXC_OE_N_O,
    output logic             TXD_O,
    output logic             TX_EMPTY_REQ_O,
    output logic             TX_DONE_O
);

    function automatic logic sst_hit(input logic [7:0] adr,
                                     input logic [7:0] off);
        sst_hit = (adr[7:2] == off[7:2]);
    endfunction : sst_hit

    // Link domain: divider that makes the master clock.
    logic                     lrst_s1_r;
    logic                     lrst_s2_r;
    logic [BAUD_DIV_LOG2-1:0] div_r;

    // Crossings and shift clock edges in the system domain.
    logic                     txc_s1_r;
    logic                     txc_s2_r;
    logic                     baud_s1_r;
    logic                     baud_s2_r;
    logic                     sclk_w;
    logic                     sclk_q_r;
    logic                     fall_w;
    logic                     rise_w;

    // Registers seen by software.
    logic                     tx_slave_select_r;
    logic                     tx_frame_length_r;
    logic                     tx_frame_mode_r;
    logic [7:0]               serial_buffer_reg_r;
    logic                     tx_buffer_empty_flag_r;
    logic                     tx_complete_flag_r;

    // Transmit engine.
    sst_pkg::sst_state_t      state_r;
    logic [7:0]               shift_r;
    logic [3:0]               cnt_r;
    logic [3:0]               cnt_nxt;
    logic [3:0]               nbits_w;
    logic                     load_w;
    logic                     frame_end_w;

    // Bus decode.
    logic                     ack_r;
    logic [31:0]              dat_r;
    logic                     access_w;
    logic                     wr_w;
    logic                     wr_ctrl_w;
    logic                     wr_stat_w;
    logic                     wr_buf_w;

    // The link domain gets its own copy of reset; the divider does not
    // honour CE_I, since the enable lives in the system domain.
    always_ff @(posedge BAUD_CLK_I) begin
        lrst_s1_r <= SRST_I;
        lrst_s2_r <= lrst_s1_r;
    end

    always_ff @(posedge BAUD_CLK_I) begin
        if (lrst_s2_r) begin
            div_r <= '0;
        end else begin
            div_r <= div_r + 1'b1;
        end
    end

    // Synchronisers run freely so that edge history stays honest
    // across a pause of CE_I.
    always_ff @(posedge CLK_I) begin
        txc_s1_r  <= TXC_I;
        txc_s2_r  <= txc_s1_r;
        baud_s1_r <= div_r[BAUD_DIV_LOG2-1];
        baud_s2_r <= baud_s1_r;
    end

    // The shift clock is the sampled pin in slave mode, else the divider.
    assign sclk_w = tx_slave_select_r ? txc_s2_r : baud_s2_r;
    assign fall_w = sclk_q_r & ~sclk_w & CE_I;
    assign rise_w = ~sclk_q_r & sclk_w & CE_I;

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            // Starts at the idle level of the pin, so that leaving reset
            // does not look like a rising shift edge.
            sclk_q_r <= 1'h1;
        end else if (CE_I) begin
            sclk_q_r <= sclk_w;
        end
    end

    // Clock pin: driven from the divider only in master mode.
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            TXC_O      <= 1'h1;
            TXC_OE_N_O <= 1'h1;
        end else if (CE_I) begin
            TXC_O      <= tx_slave_select_r ? 1'h1 : baud_s2_r;
            TXC_OE_N_O <= tx_slave_select_r;
        end
    end

    // Wishbone classic: ack comes one cycle after the request, and a
    // write takes effect at the edge where the master sees that ack.
    assign access_w  = CYC_I & STB_I & CE_I;
    assign wr_w      = access_w & ack_r & WE_I & SEL_I[0];
    assign wr_ctrl_w = wr_w & sst_hit(ADR_I, sst_pkg::OFF_CTRL);
    assign wr_stat_w = wr_w & sst_hit(ADR_I, sst_pkg::OFF_STAT);
    assign wr_buf_w  = wr_w & sst_hit(ADR_I, sst_pkg::OFF_DATA);

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            ack_r <= 1'h0;
        end else if (CE_I) begin
            ack_r <= CYC_I & STB_I & ~ack_r;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            dat_r <= 32'h0000_0000;
        end else if (access_w & ~ack_r) begin
            dat_r <= 32'h0000_0000;
            if (sst_hit(ADR_I, sst_pkg::OFF_CTRL)) begin
                dat_r[sst_pkg::CTRL_SLAVE_BIT] <= tx_slave_select_r;
                dat_r[sst_pkg::CTRL_LEN_BIT]   <= tx_frame_length_r;
                dat_r[sst_pkg::CTRL_MODE_BIT]  <= tx_frame_mode_r;
            end else if (sst_hit(ADR_I, sst_pkg::OFF_STAT)) begin
                dat_r[sst_pkg::STAT_EMPTY_BIT] <= tx_buffer_empty_flag_r;
                dat_r[sst_pkg::STAT_DONE_BIT]  <= tx_complete_flag_r;
            end else if (sst_hit(ADR_I, sst_pkg::OFF_DATA)) begin
                dat_r[7:0] <= serial_buffer_reg_r;
            end
        end
    end

    assign ACK_O = ack_r;
    assign DAT_O = dat_r;

    // Control register. Changing mode in the middle of a frame is the
    // caller's hazard: the shift clock source swaps at once.
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            tx_slave_select_r <= sst_pkg::RST_SLAVE;
            tx_frame_length_r <= sst_pkg::RST_LEN;
            tx_frame_mode_r   <= sst_pkg::RST_MODE;
        end else if (wr_ctrl_w) begin
            tx_slave_select_r <= DAT_I[sst_pkg::CTRL_SLAVE_BIT];
            tx_frame_length_r <= DAT_I[sst_pkg::CTRL_LEN_BIT];
            tx_frame_mode_r   <= DAT_I[sst_pkg::CTRL_MODE_BIT];
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            serial_buffer_reg_r <= sst_pkg::RST_BYTE;
        end else if (wr_buf_w) begin
            serial_buffer_reg_r <= DAT_I[7:0];
        end
    end

    // The buffer holds a byte exactly while the empty flag is low, so a
    // load needs no second flag.
    assign load_w = CE_I & (state_r == sst_pkg::ST_IDLE)
                  & ~tx_buffer_empty_flag_r;
    assign nbits_w = tx_frame_length_r ? sst_pkg::BITS_SHORT
                                       : sst_pkg::BITS_LONG;
    assign cnt_nxt = cnt_r + 4'h1;
    assign frame_end_w = (state_r == sst_pkg::ST_LAST) & rise_w;

    // A write in the same cycle as a load refills the buffer, so the
    // write wins and the flag stays low.
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            tx_buffer_empty_flag_r <= sst_pkg::RST_EMPTY;
        end else if (wr_buf_w) begin
            tx_buffer_empty_flag_r <= 1'h0;
        end else if (load_w) begin
            tx_buffer_empty_flag_r <= 1'h1;
        end
    end

    // Complete is cleared by a buffer write or a one written to its bit;
    // a frame that ends in the same cycle as a status clear still sets it.
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            tx_complete_flag_r <= sst_pkg::RST_DONE;
        end else if (frame_end_w & tx_buffer_empty_flag_r & ~wr_buf_w) begin
            tx_complete_flag_r <= 1'h1;
        end else if (wr_buf_w) begin
            tx_complete_flag_r <= 1'h0;
        end else if (wr_stat_w & DAT_I[sst_pkg::STAT_DONE_BIT]) begin
            tx_complete_flag_r <= 1'h0;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            TX_EMPTY_REQ_O <= sst_pkg::RST_EMPTY;
            TX_DONE_O      <= sst_pkg::RST_DONE;
        end else if (CE_I) begin
            TX_EMPTY_REQ_O <= tx_buffer_empty_flag_r;
            TX_DONE_O      <= tx_complete_flag_r;
        end
    end

    // Transmit engine. The top bit is held until the next rising shift
    // edge so that the master can still sample it.
    always_ff @(posedge CLK_I) begin
        if (SRST_I) begin
            state_r <= sst_pkg::ST_IDLE;
            shift_r <= sst_pkg::RST_BYTE;
            cnt_r   <= 4'h0;
            TXD_O   <= sst_pkg::RST_TXD;
        end else if (CE_I) begin
            case (state_r)
                sst_pkg::ST_IDLE: begin
                    if (load_w) begin
                        shift_r <= serial_buffer_reg_r;
                        cnt_r   <= 4'h0;
                        state_r <= sst_pkg::ST_SHIFT;
                    end
                end
                sst_pkg::ST_SHIFT: begin
                    if (fall_w) begin
                        TXD_O   <= shift_r[0];
                        shift_r <= {1'h0, shift_r[7:1]};
                        cnt_r   <= cnt_nxt;
                        if (cnt_nxt == nbits_w) begin
                            state_r <= sst_pkg::ST_LAST;
                        end
                    end
                end
                sst_pkg::ST_LAST: begin
                    if (rise_w) begin
                        state_r <= sst_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_r <= sst_pkg::ST_IDLE;
                end
            endcase
        end
    end

    default clocking cb @(posedge CLK_I);
    endclocking
    default disable iff (SRST_I);

    mode_drive_a: assert property (
        CE_I && !tx_slave_select_r |=> !TXC_OE_N_O)
        else $error("Clock pin not driven in master mode.");

    mode_release_a: assert property (
        CE_I && tx_slave_select_r |=> TXC_OE_N_O)
        else $error("Clock pin driven in slave mode.");

    format_write_a: assert property (
        wr_ctrl_w |=> tx_frame_length_r == $past(DAT_I[1])
                      && tx_frame_mode_r == $past(DAT_I[2]))
        else $error("Frame format bits not taken from a write.");

    pin_sample_a: assert property (
        tx_slave_select_r && fall_w && $past(CE_I)
        |-> $past(TXC_I, 3) && !$past(TXC_I, 2))
        else $error("Slave falling edge not seen on the clock pin.");

    load_delay_a: assert property (
        wr_buf_w && state_r == sst_pkg::ST_IDLE && tx_buffer_empty_flag_r
        |=> !CE_I or (load_w ##1 state_r == sst_pkg::ST_SHIFT))
        else $error("Byte not loaded one cycle after the write.");

    lsb_first_a: assert property (
        state_r == sst_pkg::ST_SHIFT && fall_w
        |=> TXD_O == $past(shift_r[0]) && cnt_r == $past(cnt_nxt))
        else $error("Wrong bit driven on a falling shift edge.");

    frame_len_a: assert property (
        $rose(state_r == sst_pkg::ST_LAST)
        |-> cnt_r == (tx_frame_length_r ? 4'h7 : 4'h8))
        else $error("Frame ended after the wrong bit count.");

    empty_set_a: assert property (
        load_w && !wr_buf_w |=> tx_buffer_empty_flag_r ##1 TX_EMPTY_REQ_O
                                || !$past(CE_I))
        else $error("Buffer-empty not set by a load.");

    done_set_a: assert property (
        frame_end_w && tx_buffer_empty_flag_r && !wr_buf_w
        |=> tx_complete_flag_r && state_r == sst_pkg::ST_IDLE)
        else $error("Transmit-complete not set at frame end.");

    empty_clear_a: assert property (
        wr_buf_w |=> !tx_buffer_empty_flag_r && !tx_complete_flag_r)
        else $error("Buffer write did not clear the flags.");

    txd_hold_a: assert property (
        !fall_w |=> $stable(TXD_O))
        else $error("Data pin moved without a falling shift edge.");

    master_clock_a: assert property (
        CE_I && !tx_slave_select_r |=> TXC_O == $past(baud_s2_r))
        else $error("Clock pin not following the divider.");

    bit_count_a: assert property (
        cnt_r <= sst_pkg::BITS_LONG)
        else $error("Bit counter ran past a long frame.");

    empty_out_a: assert property (
        CE_I |=> TX_EMPTY_REQ_O == $past(tx_buffer_empty_flag_r))
        else $error("Empty request does not follow the flag.");

    done_out_a: assert property (
        CE_I |=> TX_DONE_O == $past(tx_complete_flag_r))
        else $error("Complete output does not follow the flag.");

endmodule : sst_top

// ==== design/sst_pkg.sv ====
// Shared constants and types for the slave serial transmitter.
package sst_pkg;

    // Register byte offsets on the Wishbone bus.
    localparam logic [7:0] OFF_CTRL        = 8'h00;
    localparam logic [7:0] OFF_STAT        = 8'h04;
    localparam logic [7:0] OFF_DATA        = 8'h08;

    // Field positions in the control register.
    localparam int         CTRL_SLAVE_BIT  = 0;
    localparam int         CTRL_LEN_BIT    = 1;
    localparam int         CTRL_MODE_BIT   = 2;

    // Field positions in the status register.
    localparam int         STAT_EMPTY_BIT  = 0;
    localparam int         STAT_DONE_BIT   = 1;

    // Values after reset.
    localparam logic       RST_SLAVE       = 1'h1;
    localparam logic       RST_LEN         = 1'h0;
    localparam logic       RST_MODE        = 1'h1;
    localparam logic       RST_EMPTY       = 1'h1;
    localparam logic       RST_DONE        = 1'h0;
    localparam logic       RST_TXD         = 1'h1;
    localparam logic [7:0] RST_BYTE        = 8'h00;

    // Bits in a frame for each setting of the length bit.
    localparam logic [3:0] BITS_LONG       = 4'h8;
    localparam logic [3:0] BITS_SHORT      = 4'h7;

    // Least phase of the external shift clock, in system clock periods.
    localparam int         MIN_PHASE_CYC   = 4;

    // Default divider width of the master clock: two bits give 1/4.
    localparam int         BAUD_DIV_LOG2   = 2;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_SHIFT = 2'b01,
        ST_LAST  = 2'b10
    } sst_state_t;

endpackage : sst_pkg

// ==== test/sst_master_model.sv ====
// Behavioural external master that clocks frames out of the transmitter.
`timescale 1ns/100ps
module sst_master_model (
    input  wire logic       clk_i,
    input  wire logic       start_i,
    input  wire logic [3:0] bits_i,
    input  wire logic [3:0] phase_i,
    input  wire logic       txd_i,
    output logic            txc_o,
    output logic [7:0]      data_o,
    output logic            valid_o
);
    int n;

    initial begin
        txc_o   = 1'b1;
        data_o  = 8'h00;
        valid_o = 1'b0;
    end

    // The clock rests high between frames and never runs free.
    always @(posedge clk_i) begin
        valid_o <= 1'b0;
        if (start_i === 1'b1) begin
            n = int'(phase_i);
            if (n < sst_pkg::MIN_PHASE_CYC) n = sst_pkg::MIN_PHASE_CYC;
            data_o <= 8'h00;
            for (int i = 0; i < int'(bits_i); i++) begin
                txc_o <= 1'b0;
                repeat (n) @(posedge clk_i);
                // Taken just before the rise, after the detection delay.
                data_o[i] <= txd_i;
                txc_o <= 1'b1;
                repeat (n) @(posedge clk_i);
            end
            valid_o <= 1'b1;
        end
    end
endmodule : sst_master_model

// ==== test/sst_top_tb.sv ====
// Self-checking bench: bus master, frame checks and the verdict.
`timescale 1ns/100ps
module sst_top_tb;
    logic        clk      = 1'b0;
    logic        baud_clk = 1'b0;
    logic        srst     = 1'b1;
    logic        cyc      = 1'b0;
    logic        stb      = 1'b0;
    logic        we       = 1'b0;
    logic [7:0]  adr      = 8'h00;
    logic [3:0]  sel      = 4'hF;
    logic [31:0] dat_w    = 32'h0000_0000;
    logic        go       = 1'b0;
    logic [3:0]  nbits    = 4'h8;
    logic [3:0]  ph       = 4'h4;
    logic [31:0] dat_r;
    logic        ack, tx_clock_pin, txc_o, txc_oe_n, txd, empty_req, done, rx_valid;
    logic [7:0]  rx_data;
    logic [7:0]  exp_rx[$];
    logic [31:0] exp_rd[$];
    logic [31:0] r;
    int          fails    = 0;
    int          checked  = 0;
    int          cycles   = 0;
    int          m_cnt    = 0;
    logic        txc_q    = 1'b1;
    logic        m_arm    = 1'b0;
    logic        m_fell   = 1'b0;
    logic [7:0]  m_sh     = 8'h00;
    integer      seed     = 32'hF40E;

    always #50 clk = ~clk;
    initial begin
        #2.5;
        forever #6 baud_clk = ~baud_clk;
    end

    sst_top #(.BAUD_DIV_LOG2(7)) i_dut (
        .CLK_I(clk), .SRST_I(srst), .CE_I(1'b1), .CYC_I(cyc), .STB_I(stb),
        .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat_w), .DAT_O(dat_r),
        .ACK_O(ack), .BAUD_CLK_I(baud_clk), .TXC_I(tx_clock_pin), .TXC_O(txc_o),
        .TXC_OE_N_O(txc_oe_n), .TXD_O(txd), .TX_EMPTY_REQ_O(empty_req),
        .TX_DONE_O(done));

    sst_master_model i_master (
        .clk_i(clk), .start_i(go), .bits_i(nbits), .phase_i(ph),
        .txd_i(txd), .txc_o(tx_clock_pin), .data_o(rx_data), .valid_o(rx_valid));

    task automatic give_verdict();
        $display("checked %0d, fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("unexpected at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk

    task automatic bus(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        @(posedge clk);
        cyc   <= 1'b1;
        stb   <= 1'b1;
        we    <= w;
        adr   <= a;
        dat_w <= d;
        sel   <= s;
        @(posedge clk);
        while (ack !== 1'b1) @(posedge clk);
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, 4'hF);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_rd.push_back(e);
        bus(1'b0, a, 32'h0000_0000, 4'hF);
    endtask : rd

    // The model reads only the low bits of a short frame.
    task automatic frame(input logic [7:0] b, input logic [3:0] n);
        logic [31:0] q;
        exp_rx.push_back(n == 4'h7 ? (b & 8'h7F) : b);
        q = $random(seed);
        ph    <= 4'h4 + {2'b00, q[1:0]};
        nbits <= n;
        go    <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        while (rx_valid !== 1'b1) @(posedge clk);
    endtask : frame

    task automatic wait_done();
        int k;
        k = 0;
        while (done !== 1'b1 && k < 400) begin
            @(posedge clk);
            k++;
        end
        chk(done, 1'b1);
    endtask : wait_done

    always @(posedge clk) begin
        if (ack === 1'b1 && we === 1'b0)
            chk(dat_r,
                exp_rd.size() ? exp_rd.pop_front() : 32'hXXXX_XXXX);
        if (rx_valid === 1'b1)
            chk(rx_data,
                exp_rx.size() ? exp_rx.pop_front() : 8'hXX);
        // Master mode: the clock runs free, so bits are counted only
        // from the first falling pin edge after the byte was loaded.
        txc_q <= txc_o;
        if (m_arm && txc_q === 1'b1 && txc_o === 1'b0)
            m_fell <= 1'b1;
        if (m_fell && m_cnt < 8 && txc_q === 1'b0 && txc_o === 1'b1) begin
            m_sh  <= {txd, m_sh[7:1]};
            m_cnt <= m_cnt + 1;
            if (m_cnt == 7)
                chk({txd, m_sh[7:1]}, exp_rx.pop_front());
        end
        cycles++;
        if (cycles == 20000) begin
            fails++;
            give_verdict();
        end
    end

    initial begin
        repeat (2) @(posedge clk);
        srst <= 1'b0;
        #1 chk({27'h0, txc_oe_n, txc_o, txd, empty_req, done}, 32'h1E);
        rd(sst_pkg::OFF_CTRL, {29'h0, sst_pkg::RST_MODE, sst_pkg::RST_LEN,
           sst_pkg::RST_SLAVE});
        rd(sst_pkg::OFF_STAT, {30'h0, sst_pkg::RST_DONE,
           sst_pkg::RST_EMPTY});
        rd(8'h0C, 32'h0000_0000);
        $display("test reset values done");
        r = $random(seed);
        wr(sst_pkg::OFF_DATA, {24'h0, r[7:0]});
        @(posedge clk);
        #1 chk(empty_req, 1'b0);
        @(posedge clk);
        #1 chk(empty_req, 1'b1);
        frame(r[7:0], 4'h8);
        wait_done();
        rd(sst_pkg::OFF_STAT, 32'h0000_0003);
        wr(sst_pkg::OFF_STAT, 32'h0000_0002);
        rd(sst_pkg::OFF_STAT, 32'h0000_0001);
        $display("test single frame done");
        for (int k = 0; k < 3; k++) begin
            r = $random(seed);
            wr(sst_pkg::OFF_DATA, {24'h0, r[7:0]});
            fork
                frame(r[7:0], 4'h8);
                begin
                    repeat (5) @(posedge clk);
                    wr(sst_pkg::OFF_DATA, {24'h0, r[15:8]});
                    @(posedge clk);
                    #1 chk(empty_req, 1'b0);
                end
            join
            repeat (4) @(posedge clk);
            #1 chk(done, 1'b0);
            frame(r[15:8], 4'h8);
            wait_done();
        end
        $display("test back to back done");
        bus(1'b1, sst_pkg::OFF_DATA, 32'h0000_00A5, 4'hE);
        repeat (2) @(posedge clk);
        #1 chk(empty_req, 1'b1);
        rd(sst_pkg::OFF_DATA, {24'h0, r[15:8]});
        $display("test byte select done");
        wr(sst_pkg::OFF_CTRL, 32'h0000_0007);
        rd(sst_pkg::OFF_CTRL, 32'h0000_0007);
        r = $random(seed);
        wr(sst_pkg::OFF_DATA, {24'h0, r[7:0]});
        frame(r[7:0], 4'h7);
        wait_done();
        $display("test short frame done");
        wr(sst_pkg::OFF_CTRL, 32'h0000_0004);
        rd(sst_pkg::OFF_CTRL, 32'h0000_0004);
        repeat (3) @(posedge clk);
        #1 chk(txc_oe_n, 1'b0);
        exp_rx.push_back(r[15:8]);
        wr(sst_pkg::OFF_DATA, {24'h0, r[15:8]});
        repeat (2) @(posedge clk);
        m_arm <= 1'b1;
        wait_done();
        chk(exp_rx.size(), 0);
        chk(exp_rd.size(), 0);
        $display("test master mode done");
        give_verdict();
    end
endmodule : sst_top_tb
